/* hw/pmc_top.sv */
// power mode controller: mode sequencing, clock gating and wake logic
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_top
	import pmc_pkg::*;
(
	// clock and reset
	input  wire logic                     core_clk_in,
	input  wire logic                     resetn_in,
	// reset sources seen while powered down
	input  wire logic                     reset_pin_n_in,
	input  wire logic                     other_reset_in,
	// wishbone slave
	input  wire logic                     wb_cyc_in,
	input  wire logic                     wb_stb_in,
	input  wire logic                     wb_we_in,
	input  wire logic [7:0]               wb_adr_in,
	input  wire logic [3:0]               wb_sel_in,
	input  wire logic [31:0]              wb_dat_in,
	output logic      [31:0]              wb_dat_out,
	output logic                          wb_ack_out,
	// wake and interrupt sources
	input  wire logic                     any_irq_in,
	input  wire logic                     timer4_event_in,
	input  wire logic                     spi_byte_in,
	input  wire logic                     twi_slave_act_in,
	input  wire logic                     port_match_in,
	input  wire logic                     cmp0_in,
	input  wire logic                     logic_unit_irq_in,
	// clock and power controls
	output logic                          core_clk_en_out,
	output logic      [`PMC_PERIPH_W-1:0] periph_clk_en_out,
	output logic                          fast_osc_a_en_out,
	output logic                          fast_osc_b_en_out,
	output logic      [1:0]               system_clock_src_out,
	output logic                          reg_low_bias_out,
	output logic                          power_on_out,
	output logic                          pins_hold_out,
	output logic                          t34_slow_clk_en_out,
	output logic                          spi_wake_clk_en_out,
	// interrupt
	output logic                          irq_out
);

	pmc_state_t                r_reg;
	pmc_state_t                r_next;
	logic [`PMC_WAKE_W-1:0]    wake_ev;
	logic                      cmp0_rise;
	logic                      bus_req;
	logic                      bus_wr;
	logic                      running;
	logic                      sleeping;

	pmc_clk_if clk_if ();

	pmc_clk_div u_div (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.link        (clk_if.div)
	);

	assign clk_if.div_sel = r_reg.div_sel;
	assign clk_if.pre_en  = r_reg.pre_en;

	assign wb_dat_out           = r_reg.rdata;
	assign wb_ack_out           = r_reg.ack;
	assign core_clk_en_out      = r_reg.core_clk_en;
	assign periph_clk_en_out    = r_reg.periph_clk_en;
	assign fast_osc_a_en_out    = r_reg.fosc_a_en;
	assign fast_osc_b_en_out    = r_reg.fosc_b_en;
	assign system_clock_src_out = r_reg.src;
	assign reg_low_bias_out     = r_reg.low_bias;
	assign power_on_out         = r_reg.power_on;
	assign pins_hold_out        = r_reg.pins_hold;
	assign t34_slow_clk_en_out  = r_reg.t34_slow_en;
	assign spi_wake_clk_en_out  = r_reg.spi_run;
	assign irq_out              = r_reg.irq;

	function automatic logic [31:0] read_reg(input pmc_state_t s, input logic [7:0] adr);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (adr)
			`PMC_ADR_PWR_A:     d[1:0] = s.pwr_a;
			`PMC_ADR_PWR_B:     d[2:0] = s.pwr_b;
			`PMC_ADR_REG_CTRL:  d[`PMC_REG_DEPTH_BIT] = s.depth;
			`PMC_ADR_CLK_CTRL:  d[5:0] = {s.pre_en, s.src, s.div_sel};
			`PMC_ADR_PERIPH_EN: d[`PMC_PERIPH_W-1:0] = s.periph_en;
			`PMC_ADR_WAKE_STAT: d[`PMC_WAKE_W-1:0] = s.wake_stat;
			`PMC_ADR_WAKE_MASK: d[`PMC_WAKE_W-1:0] = s.wake_mask;
			`PMC_ADR_MODE:      d[2:0] = s.mode;
			default:            d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	always_comb begin
		r_next = r_reg;
		r_next.ack = 1'b0;
		cmp0_rise = cmp0_in && !r_reg.cmp0_prev;
		r_next.cmp0_prev = cmp0_in;
		wake_ev = '0;
		wake_ev[`PMC_WAKE_TIMER4] = timer4_event_in;
		wake_ev[`PMC_WAKE_SPI]    = spi_byte_in;
		wake_ev[`PMC_WAKE_TWI]    = twi_slave_act_in;
		wake_ev[`PMC_WAKE_PORT]   = port_match_in;
		wake_ev[`PMC_WAKE_CMP0]   = cmp0_rise;
		wake_ev[`PMC_WAKE_LOGIC]  = logic_unit_irq_in;
		bus_req = wb_cyc_in && wb_stb_in && !r_reg.ack;
		bus_wr  = bus_req && wb_we_in && wb_sel_in[0];
		if (bus_req) begin
			r_next.ack   = 1'b1;
			r_next.rdata = read_reg(r_reg, wb_adr_in);
		end
		// configuration writes
		if (bus_wr) begin
			case (wb_adr_in)
				`PMC_ADR_REG_CTRL: begin
					r_next.depth = wb_dat_in[`PMC_REG_DEPTH_BIT];
				end
				`PMC_ADR_CLK_CTRL: begin
					r_next.div_sel = wb_dat_in[`PMC_CLK_DIV_LSB +: 3];
					r_next.src     = wb_dat_in[`PMC_CLK_SRC_LSB +: 2];
					r_next.pre_en  = wb_dat_in[`PMC_CLK_PRE_BIT];
				end
				`PMC_ADR_PERIPH_EN: begin
					r_next.periph_en = wb_dat_in[`PMC_PERIPH_W-1:0];
				end
				`PMC_ADR_WAKE_MASK: begin
					r_next.wake_mask = wb_dat_in[`PMC_WAKE_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// sticky wake status: a new event wins over a write-one clear
		if (bus_wr && wb_adr_in == `PMC_ADR_WAKE_STAT) begin
			r_next.wake_stat = r_reg.wake_stat & ~wb_dat_in[`PMC_WAKE_W-1:0];
		end
		r_next.wake_stat = r_next.wake_stat | wake_ev;
		// mode sequencing
		case (r_reg.mode)
			PMC_NORMAL: begin
				if (bus_wr && wb_adr_in == `PMC_ADR_PWR_A) begin
					if (wb_dat_in[`PMC_A_PDOWN_BIT]) begin
						r_next.pwr_a[`PMC_A_PDOWN_BIT] = 1'b1;
						// depth select written beforehand picks stop or shutdown
						r_next.mode = r_reg.depth ? PMC_SHUTDOWN : PMC_STOP;
					end else if (wb_dat_in[`PMC_A_HALT_BIT]) begin
						r_next.pwr_a[`PMC_A_HALT_BIT] = 1'b1;
						r_next.mode = PMC_IDLE;
					end
				end else if (bus_wr && wb_adr_in == `PMC_ADR_PWR_B) begin
					r_next.pwr_b[`PMC_B_T34_SLOW_BIT] = wb_dat_in[`PMC_B_T34_SLOW_BIT];
					// sleep only starts once the clock already runs from oscillator A
					if (r_reg.src == `PMC_SRC_FAST_A) begin
						if (wb_dat_in[`PMC_B_SNOOZE_BIT]) begin
							r_next.pwr_b[`PMC_B_SNOOZE_BIT] = 1'b1;
							r_next.mode = PMC_SNOOZE;
						end else if (wb_dat_in[`PMC_B_SUSPEND_BIT]) begin
							r_next.pwr_b[`PMC_B_SUSPEND_BIT] = 1'b1;
							r_next.mode = PMC_SUSPEND;
						end
					end
				end
			end
			PMC_IDLE: begin
				if (any_irq_in) begin
					r_next.mode  = PMC_NORMAL;
					r_next.pwr_a = 2'h0;
				end
			end
			PMC_SUSPEND,
			PMC_SNOOZE: begin
				if (|wake_ev) begin
					r_next.mode = PMC_NORMAL;
					r_next.pwr_b[`PMC_B_SNOOZE_BIT]  = 1'b0;
					r_next.pwr_b[`PMC_B_SUSPEND_BIT] = 1'b0;
				end
			end
			PMC_STOP: begin
				if (other_reset_in || !reset_pin_n_in) begin
					r_next.mode  = PMC_NORMAL;
					r_next.pwr_a = 2'h0;
				end
			end
			PMC_SHUTDOWN: begin
				if (!reset_pin_n_in) begin
					r_next.mode  = PMC_NORMAL;
					r_next.pwr_a = 2'h0;
				end
			end
			default: begin
				r_next.mode = PMC_NORMAL;
			end
		endcase
		// clock and power controls follow the present mode
		running  = (r_reg.mode == PMC_NORMAL) || (r_reg.mode == PMC_IDLE);
		sleeping = (r_reg.mode == PMC_SUSPEND) || (r_reg.mode == PMC_SNOOZE);
		r_next.core_clk_en = (r_reg.mode == PMC_NORMAL) && clk_if.tick;
		if (running && clk_if.tick) begin
			r_next.periph_clk_en = r_reg.periph_en;
		end else begin
			r_next.periph_clk_en = '0;
		end
		r_next.fosc_a_en   = running;
		r_next.fosc_b_en   = running && (r_reg.src == `PMC_SRC_FAST_B);
		r_next.low_bias    = (r_reg.mode == PMC_SNOOZE);
		r_next.power_on    = running || sleeping;
		r_next.pins_hold   = !(running || sleeping);
		r_next.t34_slow_en = sleeping && r_reg.pwr_b[`PMC_B_T34_SLOW_BIT];
		r_next.spi_run     = sleeping;
		r_next.irq         = |(r_reg.wake_stat & r_reg.wake_mask);
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			r_reg           <= '0;
			r_reg.mode      <= PMC_NORMAL;
			r_reg.div_sel   <= `PMC_RST_DIV_SEL;
			r_reg.src       <= `PMC_RST_SRC;
			r_reg.periph_en <= `PMC_RST_PERIPH;
			r_reg.wake_mask <= `PMC_RST_MASK;
			r_reg.power_on  <= 1'b1;
			r_reg.fosc_a_en <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	sequence s_sleep_wake;
		(r_reg.mode == PMC_SUSPEND || r_reg.mode == PMC_SNOOZE) ##0 (|wake_ev);
	endsequence
	sequence s_awake_clear;
		(r_reg.mode == PMC_NORMAL) ##0 (r_reg.pwr_b[1:0] == 2'h0);
	endsequence

	property p_normal_clk;
		(r_reg.mode == PMC_NORMAL && clk_if.tick) |=> core_clk_en_out;
	endproperty
	a_normal_clk: assert property (p_normal_clk) else $error("core clock missing");

	property p_idle_halt;
		(r_reg.mode == PMC_IDLE && clk_if.tick) |=>
			!core_clk_en_out && periph_clk_en_out == $past(r_reg.periph_en);
	endproperty
	a_idle_halt: assert property (p_idle_halt) else $error("idle clocks wrong");

	property p_idle_wake;
		(r_reg.mode == PMC_IDLE && any_irq_in) |=> r_reg.mode == PMC_NORMAL && r_reg.pwr_a == 2'h0;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");

	property p_suspend_out;
		(r_reg.mode == PMC_SUSPEND) |=> !fast_osc_a_en_out && !fast_osc_b_en_out &&
			!reg_low_bias_out && !core_clk_en_out && periph_clk_en_out == '0;
	endproperty
	a_suspend_out: assert property (p_suspend_out) else $error("suspend outputs wrong");

	property p_snooze_out;
		(r_reg.mode == PMC_SNOOZE) |=> !fast_osc_a_en_out && reg_low_bias_out &&
			!core_clk_en_out && spi_wake_clk_en_out;
	endproperty
	a_snooze_out: assert property (p_snooze_out) else $error("snooze outputs wrong");

	property p_sleep_wake;
		s_sleep_wake |=> s_awake_clear;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep did not wake");

	property p_spi_byte;
		(r_reg.mode == PMC_SNOOZE && spi_byte_in) |=>
			r_reg.wake_stat[`PMC_WAKE_SPI] ##1 !spi_wake_clk_en_out;
	endproperty
	a_spi_byte: assert property (p_spi_byte) else $error("serial byte did not wake");

	property p_stop_exit;
		(r_reg.mode == PMC_STOP && other_reset_in) |=> r_reg.mode == PMC_NORMAL ##1 power_on_out;
	endproperty
	a_stop_exit: assert property (p_stop_exit) else $error("stop did not exit");

	property p_shutdown_hold;
		(r_reg.mode == PMC_SHUTDOWN && reset_pin_n_in) |=>
			r_reg.mode == PMC_SHUTDOWN && !power_on_out && pins_hold_out;
	endproperty
	a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown left early");

	property p_reset_clock;
		$past(!resetn_in) |-> r_reg.div_sel == 3'h3 && r_reg.src == 2'h0 && !r_reg.pre_en;
	endproperty
	a_reset_clock: assert property (p_reset_clock) else $error("reset clock wrong");

	property p_gate_unused;
		(running && clk_if.tick) |=> periph_clk_en_out == $past(r_reg.periph_en);
	endproperty
	a_gate_unused: assert property (p_gate_unused) else $error("peripheral gating wrong");

	property p_wake_sticky;
		(|wake_ev) |=> (r_reg.wake_stat & $past(wake_ev)) == $past(wake_ev);
	endproperty
	a_wake_sticky: assert property (p_wake_sticky) else $error("wake status lost");

	property p_sleep_refused;
		(r_reg.mode == PMC_NORMAL && r_reg.src != `PMC_SRC_FAST_A) |=>
			r_reg.mode != PMC_SUSPEND && r_reg.mode != PMC_SNOOZE;
	endproperty
	a_sleep_refused: assert property (p_sleep_refused) else $error("bad sleep");

	property p_stop_hold;
		(r_reg.mode == PMC_STOP) |=> !power_on_out && pins_hold_out;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop power wrong");

	property p_shutdown_exit;
		(r_reg.mode == PMC_SHUTDOWN && !reset_pin_n_in) |=>
			r_reg.mode == PMC_NORMAL ##1 power_on_out && !pins_hold_out;
	endproperty
	a_shutdown_exit: assert property (p_shutdown_exit) else $error("shutdown stuck");

	property p_t34_slow;
		sleeping |=> t34_slow_clk_en_out == $past(r_reg.pwr_b[`PMC_B_T34_SLOW_BIT]);
	endproperty
	a_t34_slow: assert property (p_t34_slow) else $error("slow timer clock wrong");

endmodule

/* hw/pmc_defs.svh */
// register offsets, field positions and reset values of the power mode controller
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

`define PMC_ADR_PWR_A      8'h00
`define PMC_ADR_PWR_B      8'h04
`define PMC_ADR_REG_CTRL   8'h08
`define PMC_ADR_CLK_CTRL   8'h0c
`define PMC_ADR_PERIPH_EN  8'h10
`define PMC_ADR_WAKE_STAT  8'h14
`define PMC_ADR_WAKE_MASK  8'h18
`define PMC_ADR_MODE       8'h1c

`define PMC_A_HALT_BIT     0
`define PMC_A_PDOWN_BIT    1
`define PMC_B_SUSPEND_BIT  0
`define PMC_B_SNOOZE_BIT   1
`define PMC_B_T34_SLOW_BIT 2
`define PMC_REG_DEPTH_BIT  0
`define PMC_CLK_DIV_LSB    0
`define PMC_CLK_SRC_LSB    3
`define PMC_CLK_PRE_BIT    5

`define PMC_WAKE_TIMER4    0
`define PMC_WAKE_SPI       1
`define PMC_WAKE_TWI       2
`define PMC_WAKE_PORT      3
`define PMC_WAKE_CMP0      4
`define PMC_WAKE_LOGIC     5

`define PMC_PERIPH_W       8
`define PMC_WAKE_W         6

`define PMC_SRC_FAST_A     2'h0
`define PMC_SRC_FAST_B     2'h1
`define PMC_SRC_SLOW       2'h2

`define PMC_RST_DIV_SEL    3'h3
`define PMC_RST_SRC        2'h0
`define PMC_RST_PERIPH     8'hff
`define PMC_RST_MASK       6'h00

`endif

/* hw/pmc_pkg.sv */
// types shared by the power mode controller modules
`include "pmc_defs.svh"
package pmc_pkg;

	typedef enum logic [2:0] {
		PMC_NORMAL,
		PMC_IDLE,
		PMC_SUSPEND,
		PMC_SNOOZE,
		PMC_STOP,
		PMC_SHUTDOWN
	} pmc_mode_t;

	typedef struct packed {
		pmc_mode_t                  mode;
		logic [1:0]                 pwr_a;
		logic [2:0]                 pwr_b;
		logic                       depth;
		logic [2:0]                 div_sel;
		logic [1:0]                 src;
		logic                       pre_en;
		logic [`PMC_PERIPH_W-1:0]   periph_en;
		logic [`PMC_WAKE_W-1:0]     wake_stat;
		logic [`PMC_WAKE_W-1:0]     wake_mask;
		logic                       cmp0_prev;
		logic                       ack;
		logic [31:0]                rdata;
		logic                       core_clk_en;
		logic [`PMC_PERIPH_W-1:0]   periph_clk_en;
		logic                       fosc_a_en;
		logic                       fosc_b_en;
		logic                       low_bias;
		logic                       power_on;
		logic                       pins_hold;
		logic                       t34_slow_en;
		logic                       spi_run;
		logic                       irq;
	} pmc_state_t;

	typedef struct packed {
		logic [1:0] pre_acc;
		logic [6:0] cnt;
		logic       tick;
	} pmc_div_state_t;

endpackage

/* hw/pmc_clk_if.sv */
// divider settings and system clock enable between controller and divider
`timescale 1ns/10ps
interface pmc_clk_if;
	logic [2:0] div_sel;
	logic       pre_en;
	logic       tick;
	modport ctrl (output div_sel, output pre_en, input tick);
	modport div  (input div_sel, input pre_en, output tick);
endinterface

/* hw/pmc_clk_div.sv */
// system clock enable divider: optional 1.5x prescale then divide by 2^n
`timescale 1ns/10ps
module pmc_clk_div
	import pmc_pkg::*;
(
	// clock and reset
	input  wire logic core_clk_in,
	input  wire logic resetn_in,
	// settings and enable pulse
	pmc_clk_if.div    link
);

	pmc_div_state_t r_reg;
	pmc_div_state_t r_next;
	logic           pre_tick;
	logic [6:0]     limit;

	assign link.tick = r_reg.tick;

	always_comb begin
		r_next = r_reg;
		// prescale passes two of every three cycles
		pre_tick = !link.pre_en || (r_reg.pre_acc != 2'h2);
		if (link.pre_en) begin
			r_next.pre_acc = (r_reg.pre_acc == 2'h2) ? 2'h0 : 2'(r_reg.pre_acc + 2'h1);
		end else begin
			r_next.pre_acc = 2'h0;
		end
		limit = 7'((8'h01 << link.div_sel) - 8'h01);
		r_next.tick = 1'b0;
		if (pre_tick) begin
			if (r_reg.cnt >= limit) begin
				r_next.cnt  = 7'h00;
				r_next.tick = 1'b1;
			end else begin
				r_next.cnt = 7'(r_reg.cnt + 7'h01);
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	property p_div_two;
		(r_reg.tick && !link.pre_en && link.div_sel == 3'h1) ##1
		(!link.pre_en && link.div_sel == 3'h1) |-> !r_reg.tick ##1 r_reg.tick;
	endproperty
	a_div_two: assert property (p_div_two) else $error("divide by two period wrong");

endmodule

/* hw/pmc_top_tail_unused.sv */
// empty design unit: holds no logic

/* tb/power_mode_controller_tb.sv */
// self-checking bench of the power mode controller
`timescale 1ns/10ps
`include "pmc_defs.svh"
module power_mode_controller_tb
	import pmc_pkg::*;
;
	logic        core_clk_in;
	logic        resetn_in;
	logic        reset_pin_n_in;
	logic        other_reset_in;
	logic        wb_cyc_in;
	logic        wb_stb_in;
	logic        wb_we_in;
	logic [7:0]  wb_adr_in;
	logic [3:0]  wb_sel_in;
	logic [31:0] wb_dat_in;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	logic        any_irq_in;
	logic [5:0]  wake_src;
	logic        core_clk_en_out;
	logic [7:0]  periph_clk_en_out;
	logic        fosc_a;
	logic        fosc_b;
	logic [1:0]  src_out;
	logic        low_bias;
	logic        power_on;
	logic        pins_hold;
	logic        t34_en;
	logic        spi_en;
	logic        irq_out;
	int          fail_count;
	int          checks;

	pmc_top u_dut (
		.core_clk_in          (core_clk_in),
		.resetn_in            (resetn_in),
		.reset_pin_n_in       (reset_pin_n_in),
		.other_reset_in       (other_reset_in),
		.wb_cyc_in            (wb_cyc_in),
		.wb_stb_in            (wb_stb_in),
		.wb_we_in             (wb_we_in),
		.wb_adr_in            (wb_adr_in),
		.wb_sel_in            (wb_sel_in),
		.wb_dat_in            (wb_dat_in),
		.wb_dat_out           (wb_dat_out),
		.wb_ack_out           (wb_ack_out),
		.any_irq_in           (any_irq_in),
		.timer4_event_in      (wake_src[0]),
		.spi_byte_in          (wake_src[1]),
		.twi_slave_act_in     (wake_src[2]),
		.port_match_in        (wake_src[3]),
		.cmp0_in              (wake_src[4]),
		.logic_unit_irq_in    (wake_src[5]),
		.core_clk_en_out      (core_clk_en_out),
		.periph_clk_en_out    (periph_clk_en_out),
		.fast_osc_a_en_out    (fosc_a),
		.fast_osc_b_en_out    (fosc_b),
		.system_clock_src_out (src_out),
		.reg_low_bias_out     (low_bias),
		.power_on_out         (power_on),
		.pins_hold_out        (pins_hold),
		.t34_slow_clk_en_out  (t34_en),
		.spi_wake_clk_en_out  (spi_en),
		.irq_out              (irq_out)
	);

	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction

	// core clock pulses expected in a 384 cycle window
	function automatic int exp_ticks(input logic pre, input logic [2:0] div);
		return pre ? (256 >> div) : (384 >> div);
	endfunction

	task automatic report_and_stop;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic cycle; ack and read data are taken at the rising edge that sees ack high
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
			input logic [3:0] sel, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge core_clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in  <= we;
		wb_adr_in <= adr;
		wb_sel_in <= sel;
		wb_dat_in <= d;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 32);
		if (n >= 32) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, wb_ack_out, 1'b1);
		end
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, adr, d, 4'hf, x);
	endtask

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] x;
		wb(1'b0, adr, 32'h0, 4'hf, x);
		chk(x, exp);
	endtask

	task automatic settle;
		repeat (3) @(posedge core_clk_in);
		@(negedge core_clk_in);
	endtask

	task automatic ticks(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge core_clk_in);
			c += (core_clk_en_out === 1'b1) ? 1 : 0;
		end
	endtask

	task automatic pulse(input int i);
		@(posedge core_clk_in);
		wake_src <= 6'h1 << i;
		@(posedge core_clk_in);
		wake_src <= 6'h0;
	endtask

	task automatic pulse_other;
		@(posedge core_clk_in);
		other_reset_in <= 1'b1;
		@(posedge core_clk_in);
		other_reset_in <= 1'b0;
	endtask

	initial begin
		repeat (40000) @(posedge core_clk_in);
		fail_count++;
		report_and_stop;
	end

	initial begin
		logic [31:0] seed;
		logic [31:0] got;
		logic [7:0]  use_v;
		logic        sn;
		int          c;
		int          k;
		seed = 32'hb1ac70f9;
		fail_count = 0;
		checks = 0;
		resetn_in = 1'b0;
		reset_pin_n_in = 1'b1;
		other_reset_in = 1'b0;
		wb_cyc_in = 1'b0;
		wb_stb_in = 1'b0;
		wb_we_in = 1'b0;
		wb_adr_in = 8'h00;
		wb_sel_in = 4'h0;
		wb_dat_in = 32'h0;
		any_irq_in = 1'b0;
		wake_src = 6'h00;
		repeat (4) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		settle;
		chk({30'h0, fosc_a, fosc_b}, 32'h2);
		rd_chk(`PMC_ADR_CLK_CTRL, 32'h3);
		ticks(64, c);
		chk(c, 8);
		rd_chk(`PMC_ADR_PERIPH_EN, 32'hff);
		rd_chk(`PMC_ADR_MODE, 32'h0);
		rd_chk(8'h20, 32'h0);
		wb(1'b1, `PMC_ADR_WAKE_MASK, 32'h3f, 4'he, got);
		rd_chk(`PMC_ADR_WAKE_MASK, 32'h0);
		// every divide setting, with and without the prescaler
		for (k = 0; k < 16; k++) begin
			wr(`PMC_ADR_CLK_CTRL, {26'h0, k[3], 2'h0, k[2:0]});
			repeat (130) @(posedge core_clk_in);
			ticks(384, c);
			chk(c, exp_ticks(k[3], k[2:0]));
		end
		wr(`PMC_ADR_CLK_CTRL, 32'h0);
		for (k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			use_v = seed[7:0];
			wr(`PMC_ADR_PERIPH_EN, {24'h0, use_v});
			settle;
			chk(32'(periph_clk_en_out), 32'(use_v));
			chk(32'(core_clk_en_out), 32'h1);
		end
		// sleep refused while running from the other fast oscillator
		wr(`PMC_ADR_CLK_CTRL, 32'h8);
		settle;
		chk({30'h0, src_out}, 32'h1);
		chk(32'(fosc_b), 32'h1);
		wr(`PMC_ADR_PWR_B, 32'h1);
		settle;
		rd_chk(`PMC_ADR_MODE, 32'h0);
		rd_chk(`PMC_ADR_PWR_B, 32'h0);
		wr(`PMC_ADR_CLK_CTRL, 32'h0);
		// idle
		wr(`PMC_ADR_PWR_A, 32'h1);
		settle;
		rd_chk(`PMC_ADR_MODE, 32'(PMC_IDLE));
		ticks(16, c);
		chk(c, 0);
		chk(32'(periph_clk_en_out), 32'(use_v));
		seed = lfsr(seed);
		repeat (seed[3:0]) @(posedge core_clk_in);
		@(posedge core_clk_in);
		any_irq_in <= 1'b1;
		@(posedge core_clk_in);
		any_irq_in <= 1'b0;
		settle;
		rd_chk(`PMC_ADR_PWR_A, 32'h0);
		ticks(16, c);
		chk(c, 16);
		// suspend and snooze, woken by each source in turn
		wr(`PMC_ADR_WAKE_MASK, 32'h3f);
		for (k = 0; k < 12; k++) begin
			sn = k[0];
			wr(`PMC_ADR_PWR_B, {29'h0, k[1], sn, ~sn});
			settle;
			rd_chk(`PMC_ADR_MODE, sn ? 32'(PMC_SNOOZE) : 32'(PMC_SUSPEND));
			chk({core_clk_en_out, periph_clk_en_out, fosc_a, fosc_b}, 32'h0);
			chk(32'(low_bias), 32'(sn));
			chk({30'h0, t34_en, spi_en}, {30'h0, k[1], 1'b1});
			seed = lfsr(seed);
			repeat (seed[2:0]) @(posedge core_clk_in);
			pulse(k >> 1);
			settle;
			rd_chk(`PMC_ADR_MODE, 32'h0);
			rd_chk(`PMC_ADR_PWR_B, {29'h0, k[1], 2'h0});
			chk({30'h0, fosc_a, irq_out}, 32'h3);
			rd_chk(`PMC_ADR_WAKE_STAT, 32'h1 << (k >> 1));
			wr(`PMC_ADR_WAKE_STAT, 32'h1 << (k >> 1));
			settle;
			chk(32'(irq_out), 32'h0);
		end
		// masked event stays silent until unmasked
		wr(`PMC_ADR_WAKE_MASK, 32'h3e);
		pulse(0);
		settle;
		chk(32'(irq_out), 32'h0);
		wr(`PMC_ADR_WAKE_MASK, 32'h3f);
		settle;
		chk(32'(irq_out), 32'h1);
		wr(`PMC_ADR_WAKE_STAT, 32'h1);
		settle;
		chk(32'(irq_out), 32'h0);
		// stop ends on the other reset source
		wr(`PMC_ADR_REG_CTRL, 32'h0);
		wr(`PMC_ADR_PWR_A, 32'h2);
		settle;
		rd_chk(`PMC_ADR_MODE, 32'(PMC_STOP));
		chk({30'h0, power_on, pins_hold}, 32'h1);
		pulse_other;
		settle;
		chk({30'h0, power_on, pins_hold}, 32'h2);
		rd_chk(`PMC_ADR_PWR_A, 32'h0);
		// a core reset in mid-run also ends stop
		wr(`PMC_ADR_PWR_A, 32'h2);
		settle;
		@(posedge core_clk_in);
		resetn_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		settle;
		chk({30'h0, power_on, pins_hold}, 32'h2);
		rd_chk(`PMC_ADR_CLK_CTRL, 32'h3);
		// shutdown ignores other resets, ends on the pin
		wr(`PMC_ADR_REG_CTRL, 32'h1);
		wr(`PMC_ADR_PWR_A, 32'h2);
		settle;
		rd_chk(`PMC_ADR_MODE, 32'(PMC_SHUTDOWN));
		pulse_other;
		settle;
		chk({30'h0, power_on, pins_hold}, 32'h1);
		@(posedge core_clk_in);
		reset_pin_n_in <= 1'b0;
		@(posedge core_clk_in);
		reset_pin_n_in <= 1'b1;
		settle;
		chk({30'h0, power_on, pins_hold}, 32'h2);
		rd_chk(`PMC_ADR_MODE, 32'h0);
		report_and_stop;
	end
endmodule
